// file: hw/rpq_rx_qualifier.sv
// Receive packet qualifier: sync search, length, address filter, CRC outcome, status append.
// Assumes a demodulator delivering bits MSB first, an external CRC unit and a receive FIFO.
`timescale 1ns/1ps
`default_nettype none

module rpq_rx_qualifier
	import rpq_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	// Register port
	input  wire logic [5:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// Demodulated stream and radio state
	input  wire logic       rx_enable,
	input  wire logic       rx_bit_valid,
	input  wire logic       rx_bit,
	input  wire logic       wor_mode,
	input  wire logic [7:0] rssi_value,
	input  wire logic [6:0] link_quality_value,
	// External CRC result
	input  wire logic       crc_done,
	input  wire logic       crc_ok,
	// Receive FIFO side
	output logic            fifo_wr_en,
	output logic      [7:0] fifo_wr_data,
	output logic            fifo_flush,
	// Events and status
	output logic            sync_accepted,
	output logic            wor_timer_reset,
	output logic            packet_done,
	output logic      [3:0] fifo_level_threshold,
	output logic      [4:0] preamble_quality
);

	// ****************************************************
	// Registers
	// ****************************************************
	logic [7:0] fifo_threshold_ctrl; // FIFO level setting, used by the FIFO
	logic [7:0] sync_word_hi;        // Upper sync byte
	logic [7:0] sync_word_lo;        // Lower sync byte
	logic [7:0] packet_length_limit; // Fixed length or maximum length
	logic [7:0] rx_packet_control;   // Quality, autosync, flush, append, filter
	logic [7:0] packet_format_ctrl;  // CRC enable and length mode
	logic [7:0] node_address;        // Own address for filtering

	// Decoded fields
	logic [2:0] preamble_quality_threshold;
	logic       wake_timer_autosync;
	logic       bad_check_rx_flush;
	logic       status_byte_append;
	logic [1:0] addr_filter_mode;
	logic       crc_enable;
	logic [1:0] length_mode;

	assign preamble_quality_threshold = rx_packet_control[PQG_HI:PQG_LO];
	assign wake_timer_autosync        = rx_packet_control[BIT_AUTOSYNC];
	assign bad_check_rx_flush         = rx_packet_control[BIT_AUTOFLSH];
	assign status_byte_append         = rx_packet_control[BIT_APPEND];
	assign addr_filter_mode           = rx_packet_control[ADR_HI:ADR_LO];
	assign crc_enable                 = packet_format_ctrl[BIT_CRC_EN];
	assign length_mode                = packet_format_ctrl[LEN_HI:LEN_LO];

	// ****************************************************
	// Register writes
	// ****************************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			fifo_threshold_ctrl <= RST_FIFO_LVL;
			sync_word_hi        <= RST_SYNC_HI;    // [RULE1]
			sync_word_lo        <= RST_SYNC_LO;    // [RULE2]
			packet_length_limit <= RST_PKT_LEN;    // [RULE3]
			rx_packet_control   <= RST_RX_CTRL;    // [RULE12]
			packet_format_ctrl  <= RST_PKT_FORMAT;
			node_address        <= RST_NODE_ADDR;  // [RULE16]
		end else if (reg_wr) begin
			case (reg_addr)
				REG_FIFO_LVL:   fifo_threshold_ctrl <= reg_wdata & MASK_FIFO_LVL;
				REG_SYNC_HI:    sync_word_hi        <= reg_wdata; // [RULE1]
				REG_SYNC_LO:    sync_word_lo        <= reg_wdata; // [RULE2]
				REG_PKT_LEN:    packet_length_limit <= reg_wdata;
				REG_RX_CTRL:    rx_packet_control   <= reg_wdata & MASK_RX_CTRL;
				REG_PKT_FORMAT: packet_format_ctrl  <= reg_wdata & MASK_FORMAT;
				REG_NODE_ADDR:  node_address        <= reg_wdata; // [RULE16]
				default: ;      // Unmapped writes are dropped
			endcase
		end
	end

	// ****************************************************
	// Register reads
	// ****************************************************
	// Read data is registered; unmapped offsets read zero
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_FIFO_LVL:   reg_rdata <= fifo_threshold_ctrl;
				REG_SYNC_HI:    reg_rdata <= sync_word_hi;
				REG_SYNC_LO:    reg_rdata <= sync_word_lo;
				REG_PKT_LEN:    reg_rdata <= packet_length_limit;
				REG_RX_CTRL:    reg_rdata <= rx_packet_control;
				REG_PKT_FORMAT: reg_rdata <= packet_format_ctrl;
				REG_NODE_ADDR:  reg_rdata <= node_address;
				default:        reg_rdata <= 8'h00;
			endcase
		end
	end

	// FIFO threshold is handed on as a flopped copy
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			fifo_level_threshold <= RST_FIFO_LVL[3:0];
		else
			fifo_level_threshold <= fifo_threshold_ctrl[3:0];
	end

	// ****************************************************
	// Preamble quality and sync search
	// ****************************************************
	rpq_state_e state;        // Sequencer state
	rpq_state_e next_state;
	logic [15:0] sync_sr;     // Last sixteen received bits
	logic [15:0] sync_window; // Window including the current bit
	logic [4:0]  pq_gate;     // Four times the threshold field
	logic        pq_ok;       // Quality gate open
	logic        sync_hit;    // Accepted sync word this cycle

	rpq_quality_counter u_quality (
		.core_clk     (core_clk),
		.arst_n       (arst_n),
		.rx_bit_valid (rx_bit_valid),
		.rx_bit       (rx_bit),
		.clear        (!rx_enable),
		.quality      (preamble_quality)
	);

	assign sync_window = {sync_sr[14:0], rx_bit};
	assign pq_gate     = {preamble_quality_threshold, 2'b00};               // [RULE7]
	assign pq_ok       = (preamble_quality_threshold == 3'h0) ||            // [RULE8]
	                     (preamble_quality >= pq_gate);                     // [RULE7]
	assign sync_hit    = rx_enable && rx_bit_valid && (state == RPQ_HUNT) &&
	                     (sync_window == {sync_word_hi, sync_word_lo}) && pq_ok;

	// Sync shift register runs on every bit
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			sync_sr <= 16'h0000;
		else if (rx_bit_valid)
			sync_sr <= sync_window;
	end

	// ****************************************************
	// Byte assembly
	// ****************************************************
	logic [6:0] byte_sr;   // Bits of the byte under way
	logic [2:0] bit_cnt;   // Bits already taken of the byte
	logic [7:0] byte_now;  // Completed byte
	logic       byte_done; // A byte completes this cycle

	assign byte_now  = {byte_sr, rx_bit};
	assign byte_done = rx_bit_valid && (bit_cnt == BIT_LAST) &&
	                   ((state == RPQ_LEN) || (state == RPQ_BODY));

	// Bit counter restarts at every sync so bytes align to the sync word
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			byte_sr <= 7'h00;
			bit_cnt <= 3'h0;
		end else if (state == RPQ_HUNT) begin
			bit_cnt <= 3'h0;
		end else if (rx_bit_valid) begin
			byte_sr <= byte_now[6:0];
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	// ****************************************************
	// Address filter
	// ****************************************************
	logic addr_pass; // Current byte passes the address filter

	always_comb begin
		case (addr_filter_mode)
			ADR_NODE:   addr_pass = (byte_now == node_address);                    // [RULE13]
			ADR_BCAST0: addr_pass = (byte_now == node_address) ||                  // [RULE14]
			                        (byte_now == BCAST_LOW);
			ADR_BCAST2: addr_pass = (byte_now == node_address) ||                  // [RULE15]
			                        (byte_now == BCAST_LOW) || (byte_now == BCAST_HIGH);
			default:    addr_pass = 1'b1;                                          // [RULE13]
		endcase
	end

	// ****************************************************
	// Packet sequencer
	// ****************************************************
	logic [7:0] remain;      // Body bytes still to come
	logic [7:0] next_remain;
	logic       addr_due;    // Next body byte is the address
	logic       next_addr_due;
	logic       crc_flag;    // CRC outcome for the status byte
	logic       next_crc_flag;
	logic       next_wr;
	logic [7:0] next_data;
	logic       next_flush;
	logic       next_done;
	rpq_state_e tail_state;  // Where a finished body goes

	// After the body: CRC wait, status bytes or back to hunting
	always_comb begin
		if (crc_enable)
			tail_state = RPQ_CRC;
		else if (status_byte_append)
			tail_state = RPQ_STAT1;
		else
			tail_state = RPQ_HUNT;
	end

	always_comb begin
		next_state    = state;
		next_remain   = remain;
		next_addr_due = addr_due;
		next_crc_flag = crc_flag;
		next_wr       = 1'b0;
		next_data     = fifo_wr_data;
		next_flush    = 1'b0;
		next_done     = 1'b0;
		case (state)
			RPQ_HUNT: begin
				next_addr_due = (addr_filter_mode != ADR_NONE);
				next_crc_flag = 1'b1;
				if (sync_hit) begin
					if (length_mode == LEN_VAR)
						next_state = RPQ_LEN;                 // [RULE17]
					else begin
						next_remain = packet_length_limit;    // [RULE3]
						next_state  = (length_mode == LEN_FIXED && packet_length_limit == 8'h00) ?
						              tail_state : RPQ_BODY;
					end
				end
			end
			RPQ_LEN: begin
				if (byte_done) begin
					next_wr   = (byte_now <= packet_length_limit);
					next_data = byte_now;                     // [RULE17]
					next_remain = byte_now;
					if (byte_now > packet_length_limit) begin // [RULE4]
						next_flush = 1'b1;                    // [RULE19]
						next_state = RPQ_HUNT;
					end else if (byte_now == 8'h00)
						next_state = tail_state;
					else
						next_state = RPQ_BODY;
				end
			end
			RPQ_BODY: begin
				if (byte_done) begin
					next_addr_due = 1'b0;
					if (addr_due && !addr_pass) begin
						// Length byte may already sit in the FIFO, so flush
						next_flush = 1'b1;                    // [RULE18]
						next_state = RPQ_HUNT;
					end else begin
						next_wr     = 1'b1;
						next_data   = byte_now;
						next_remain = remain - 8'h01;
						// Infinite mode never ends the body by count
						if (remain == 8'h01 && length_mode != LEN_INF)
							next_state = tail_state;
					end
				end
			end
			RPQ_CRC: begin
				if (crc_done) begin
					next_crc_flag = crc_ok;
					if (!crc_ok && bad_check_rx_flush) begin
						next_flush = 1'b1;                    // [RULE10] [RULE11]
						next_done  = 1'b1;
						next_state = RPQ_HUNT;
					end else if (status_byte_append)
						next_state = RPQ_STAT1;
					else begin
						next_done  = 1'b1;
						next_state = RPQ_HUNT;
					end
				end
			end
			RPQ_STAT1: begin
				next_wr    = 1'b1;
				next_data  = rssi_value;                      // [RULE12]
				next_state = RPQ_STAT2;
			end
			RPQ_STAT2: begin
				next_wr    = 1'b1;
				next_data  = {crc_flag, link_quality_value};  // [RULE12]
				next_done  = 1'b1;
				next_state = RPQ_HUNT;
			end
			default: next_state = RPQ_HUNT;
		endcase
		// Disabling the receiver abandons any packet in progress
		if (!rx_enable) begin
			next_state = RPQ_HUNT;
			next_wr    = 1'b0;
		end
	end

	// Sequencer state and packet bookkeeping
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state    <= RPQ_HUNT;
			remain   <= 8'h00;
			addr_due <= 1'b0;
			crc_flag <= 1'b1;
		end else begin
			state    <= next_state;
			remain   <= next_remain;
			addr_due <= next_addr_due;
			crc_flag <= next_crc_flag;
		end
	end

	// ****************************************************
	// FIFO side and event outputs
	// ****************************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			fifo_wr_en   <= 1'b0;
			fifo_wr_data <= 8'h00;
			fifo_flush   <= 1'b0;
			packet_done  <= 1'b0;
		end else begin
			fifo_wr_en   <= next_wr;
			fifo_wr_data <= next_data;
			fifo_flush   <= next_flush;
			packet_done  <= next_done;
		end
	end

	// Sync pulse and wake timer resynchronisation
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync_accepted   <= 1'b0;
			wor_timer_reset <= 1'b0;
		end else begin
			sync_accepted   <= sync_hit;
			wor_timer_reset <= sync_hit && wor_mode && wake_timer_autosync; // [RULE9]
		end
	end

endmodule // rpq_rx_qualifier

`default_nettype wire

// file: shared/rpq_pkg.sv
// Constants, register map and state encoding for the receive packet qualifier.
// Assumes a byte-wide register port and a demodulated serial bit stream, MSB first.
//
// Behaviour
// [RULE1] Sync high byte register, resets to 0xD3
// [RULE2] Sync low byte register, resets to 0x91
// [RULE3] Fixed mode takes length from length register
// [RULE4] Variable mode: length register is maximum length
// [RULE5] Quality counter: +1 on change, -4 on repeat
// [RULE6] Quality counter saturates at 0 and 31
// [RULE7] Sync accepted when counter reaches four times threshold
// [RULE8] Threshold zero accepts every sync word
// [RULE9] Autosync resets wake timer on sync word
// [RULE10] Autoflush empties receive FIFO on CRC failure
// [RULE11] Controller keeps one short packet in FIFO
// [RULE12] Status append adds RSSI, quality and CRC flag
// [RULE13] Filter 00 none, 01 node address only
// [RULE14] Filter 10 also accepts address 0x00
// [RULE15] Filter 11 accepts node, 0x00 or 0xFF
// [RULE16] Node address register, resets to zero
// [RULE17] Variable mode length is first byte after sync
// [RULE18] Address mismatch packet is flushed from FIFO
// [RULE19] Oversize variable length packet is discarded
package rpq_pkg;

	// ****************************************************
	// Register offsets
	// ****************************************************
	localparam logic [5:0] REG_FIFO_LVL   = 6'h03;
	localparam logic [5:0] REG_SYNC_HI    = 6'h04;
	localparam logic [5:0] REG_SYNC_LO    = 6'h05;
	localparam logic [5:0] REG_PKT_LEN    = 6'h06;
	localparam logic [5:0] REG_RX_CTRL    = 6'h07;
	localparam logic [5:0] REG_PKT_FORMAT = 6'h08;
	localparam logic [5:0] REG_NODE_ADDR  = 6'h09;

	// ****************************************************
	// Reset values
	// ****************************************************
	localparam logic [7:0] RST_FIFO_LVL   = 8'h07;
	localparam logic [7:0] RST_SYNC_HI    = 8'hD3;
	localparam logic [7:0] RST_SYNC_LO    = 8'h91;
	localparam logic [7:0] RST_PKT_LEN    = 8'hFF;
	localparam logic [7:0] RST_RX_CTRL    = 8'h04;
	localparam logic [7:0] RST_PKT_FORMAT = 8'h05;
	localparam logic [7:0] RST_NODE_ADDR  = 8'h00;

	// ****************************************************
	// Field positions
	// ****************************************************
	localparam int PQG_HI       = 7;
	localparam int PQG_LO       = 5;
	localparam int BIT_AUTOSYNC = 4;
	localparam int BIT_AUTOFLSH = 3;
	localparam int BIT_APPEND   = 2;
	localparam int ADR_HI       = 1;
	localparam int ADR_LO       = 0;
	localparam int BIT_CRC_EN   = 2;
	localparam int LEN_HI       = 1;
	localparam int LEN_LO       = 0;
	localparam logic [7:0] MASK_FIFO_LVL = 8'hFF;
	localparam logic [7:0] MASK_RX_CTRL  = 8'hFF;
	localparam logic [7:0] MASK_FORMAT   = 8'h07;

	// ****************************************************
	// Encodings and counter figures
	// ****************************************************
	localparam logic [1:0] ADR_NONE   = 2'h0;
	localparam logic [1:0] ADR_NODE   = 2'h1;
	localparam logic [1:0] ADR_BCAST0 = 2'h2;
	localparam logic [1:0] ADR_BCAST2 = 2'h3;
	localparam logic [7:0] BCAST_LOW  = 8'h00;
	localparam logic [7:0] BCAST_HIGH = 8'hFF;
	localparam logic [1:0] LEN_FIXED  = 2'h0;
	localparam logic [1:0] LEN_VAR    = 2'h1;
	localparam logic [1:0] LEN_INF    = 2'h2;
	localparam logic [4:0] PQ_MAX     = 5'h1F;
	localparam logic [4:0] PQ_DROP    = 5'h04;
	localparam logic [2:0] BIT_LAST   = 3'h7;

	// Receive sequencer states, one-hot
	typedef enum logic [5:0] {
		RPQ_HUNT  = 6'h01,
		RPQ_LEN   = 6'h02,
		RPQ_BODY  = 6'h04,
		RPQ_CRC   = 6'h08,
		RPQ_STAT1 = 6'h10,
		RPQ_STAT2 = 6'h20
	} rpq_state_e;

endpackage

// file: hw/rpq_quality_counter.sv
// Preamble quality counter fed by the received bit stream.
// Assumes one qualified bit per rx_bit_valid cycle.
`timescale 1ns/1ps
`default_nettype none

module rpq_quality_counter
	import rpq_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	// Bit stream
	input  wire logic       rx_bit_valid,
	input  wire logic       rx_bit,
	input  wire logic       clear,
	// Counter value
	output logic      [4:0] quality
);

	logic prev_bit;   // Bit received before the current one
	logic have_prev;  // No comparison before the first bit

	// ****************************************************
	// Counter update
	// ****************************************************
	// Clear restarts the estimate so a stale preamble never gates a new hunt
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			quality   <= 5'h00;
			prev_bit  <= 1'b0;
			have_prev <= 1'b0;
		end else if (clear) begin
			quality   <= 5'h00;
			have_prev <= 1'b0;
		end else if (rx_bit_valid) begin
			prev_bit  <= rx_bit;
			have_prev <= 1'b1;
			if (have_prev && (rx_bit != prev_bit)) begin
				// Transition: climb, capped at the top
				if (quality != PQ_MAX)
					quality <= quality + 5'h01; // [RULE5] [RULE6]
			end else if (have_prev) begin
				// Repeat: fall, floored at zero
				if (quality > PQ_DROP)
					quality <= quality - PQ_DROP; // [RULE5]
				else
					quality <= 5'h00; // [RULE6]
			end
		end
	end

endmodule // rpq_quality_counter

`default_nettype wire

// file: verif/rpq_rx_qualifier_assertions.sv
// Port checker for the receive packet qualifier.
// Assumes it is bound to rpq_rx_qualifier and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module rpq_checker
	import rpq_pkg::*;
(
	// Clock, reset and register writes
	input wire logic       core_clk,
	input wire logic       arst_n,
	input wire logic [5:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	// Stream and CRC inputs
	input wire logic       rx_enable,
	input wire logic       rx_bit_valid,
	input wire logic       rx_bit,
	input wire logic       wor_mode,
	input wire logic [7:0] rssi_value,
	input wire logic [6:0] link_quality_value,
	input wire logic       crc_done,
	input wire logic       crc_ok,
	// Outputs under watch
	input wire logic       fifo_wr_en,
	input wire logic [7:0] fifo_wr_data,
	input wire logic       fifo_flush,
	input wire logic       sync_accepted,
	input wire logic       wor_timer_reset,
	input wire logic       packet_done,
	input wire logic [4:0] preamble_quality
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	// ************************************************
	// Shadow state
	// ************************************************
	logic [7:0] ctl;      // Copy of the control register
	logic       last_bit; // Previous bit
	logic       have_bit; // First bit after enable is not compared

	// Control shadow follows writes on the same edge
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) ctl <= RST_RX_CTRL;
		else if (reg_wr && reg_addr == REG_RX_CTRL) ctl <= reg_wdata;
	end

	// Previous bit tracker
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			last_bit <= 1'b0;
			have_bit <= 1'b0;
		end else if (!rx_enable) begin
			have_bit <= 1'b0;
		end else if (rx_bit_valid) begin
			last_bit <= rx_bit;
			have_bit <= 1'b1;
		end
	end

	// ************************************************
	// Properties
	// ************************************************
	property p_q_up;
		rx_enable && rx_bit_valid && have_bit && rx_bit != last_bit |=> preamble_quality ==
			(($past(preamble_quality) == PQ_MAX) ? PQ_MAX : $past(preamble_quality) + 5'h01);
	endproperty
	a_q_up: assert property (p_q_up) else $error("quality rise wrong");
	property p_q_down;
		rx_enable && rx_bit_valid && have_bit && rx_bit == last_bit |=> preamble_quality ==
			(($past(preamble_quality) < PQ_DROP) ? 5'h00 : $past(preamble_quality) - PQ_DROP);
	endproperty
	a_q_down: assert property (p_q_down) else $error("quality fall wrong");
	property p_gate;
		sync_accepted && ctl[7:5] != 3'h0 |-> $past(preamble_quality) >= {ctl[7:5], 2'b00};
	endproperty
	a_gate: assert property (p_gate) else $error("sync accepted below threshold");
	property p_sync_cause;
		sync_accepted |-> $past(rx_bit_valid) && $past(rx_enable);
	endproperty
	a_sync_cause: assert property (p_sync_cause) else $error("sync without bit");
	property p_wor;
		wor_timer_reset == (sync_accepted && wor_mode && ctl[BIT_AUTOSYNC]);
	endproperty
	a_wor: assert property (p_wor) else $error("wake timer reset wrong");
	property p_flush;
		crc_done && !crc_ok && ctl[BIT_AUTOFLSH] |=> fifo_flush && packet_done && !fifo_wr_en;
	endproperty
	a_flush: assert property (p_flush) else $error("no flush on bad check");
	property p_status;
		crc_done && crc_ok && ctl[BIT_APPEND] |=> ##1 fifo_wr_en && fifo_wr_data == rssi_value
			##1 fifo_wr_en && fifo_wr_data == {1'b1, link_quality_value} && packet_done;
	endproperty
	a_status: assert property (p_status) else $error("status bytes wrong");
	property p_no_status;
		crc_done && crc_ok && !ctl[BIT_APPEND] |=> packet_done && !fifo_wr_en;
	endproperty
	a_no_status: assert property (p_no_status) else $error("status byte unwanted");
	property p_flush_alone;
		fifo_flush |-> !fifo_wr_en;
	endproperty
	a_flush_alone: assert property (p_flush_alone) else $error("write during flush");
endmodule // rpq_checker

bind rpq_rx_qualifier rpq_checker u_chk (.core_clk, .arst_n, .reg_addr, .reg_wr, .reg_wdata,
	.rx_enable, .rx_bit_valid, .rx_bit, .wor_mode, .rssi_value, .link_quality_value, .crc_done,
	.crc_ok, .fifo_wr_en, .fifo_wr_data, .fifo_flush, .sync_accepted, .wor_timer_reset,
	.packet_done, .preamble_quality);

`default_nettype wire

// file: verif/rpq_tx_model.sv
// Remote transmitter model: demodulated bits, MSB first.
// Assumes callers enter its tasks 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module rpq_tx_model (
	// Clock
	input  wire logic core_clk,
	// Demodulated stream
	output logic      rx_bit_valid,
	output logic      rx_bit
);
	int gap = 1; // Cycles per bit, 1 is back to back

	initial begin
		rx_bit_valid = 1'b0;
		rx_bit       = 1'b0;
	end

	// One byte, slow senders idle between bits
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			rx_bit_valid = 1'b1;
			rx_bit       = b[i];
			@(posedge core_clk);
			#1;
			if (gap > 1) begin
				rx_bit_valid = 1'b0;
				rx_bit       = ~rx_bit; // Line is meaningless off a bit
				repeat (gap - 1) @(posedge core_clk);
				#1;
			end
		end
	endtask

	// End of frame: stale data must not look like a held bit
	task automatic stop();
		rx_bit_valid = 1'b0;
		rx_bit       = ~rx_bit;
	endtask
endmodule // rpq_tx_model

`default_nettype wire

// file: verif/tb.sv
// Testbench for the receive packet qualifier.
// Assumes the bound checker and the transmitter model.
`timescale 1ns/1ps
`default_nettype none

module tb
	import rpq_pkg::*;
;
	logic       core_clk = 1'b0;
	logic       arst_n, reg_wr, reg_rd, rx_enable, wor_mode, crc_done, crc_ok;
	logic [5:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rssi_value, fifo_wr_data;
	logic [6:0] link_quality_value;
	logic       rx_bit_valid, rx_bit, fifo_wr_en, fifo_flush, sync_accepted, wor_timer_reset, packet_done, ok;
	logic [3:0] fifo_level_threshold;
	logic [4:0] preamble_quality;
	logic [7:0] q[$];                               // Receive FIFO model
	logic [7:0] sh = 8'hD3, sl = 8'h91;             // Current sync word
	logic [7:0] adr[4] = '{8'h42, 8'h00, 8'hFF, 8'h13};
	int         err_count = 0, check_count = 0, n_sync = 0, n_wor = 0;

	always #2.5 core_clk = ~core_clk;

	rpq_rx_qualifier DUT (.core_clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.rx_enable, .rx_bit_valid, .rx_bit, .wor_mode, .rssi_value, .link_quality_value, .crc_done,
		.crc_ok, .fifo_wr_en, .fifo_wr_data, .fifo_flush, .sync_accepted, .wor_timer_reset,
		.packet_done, .fifo_level_threshold, .preamble_quality);
	rpq_tx_model tx (.core_clk, .rx_bit_valid, .rx_bit);

	// Receive FIFO model and event counters
	always @(posedge core_clk) begin
		if (fifo_flush) q.delete();
		if (fifo_wr_en) q.push_back(fifo_wr_data);
		if (sync_accepted) n_sync++;
		if (wor_timer_reset) n_wor++;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		tick(1);
		reg_wr = 1'b0;
		tick(1);
	endtask

	// Read data is ready 1 ns after the taking edge
	task automatic rd(input logic [5:0] a, input logic [7:0] e, input string n);
		reg_addr = a;
		reg_rd   = 1'b1;
		tick(1);
		reg_rd = 1'b0;
		check(n, reg_rdata, e);
		tick(1);
	endtask

	task automatic frame(input int npre, input logic [7:0] d[$]);
		q.delete();
		repeat (npre) tx.send_byte(8'hAA);
		tx.send_byte(sh);
		tx.send_byte(sl);
		foreach (d[i]) tx.send_byte(d[i]);
		tx.stop();
		tick(4);
	endtask

	// Only one packet is ever in the FIFO model here
	task automatic crc(input logic good);
		crc_ok   = good;
		crc_done = 1'b1;
		tick(1);
		crc_done = 1'b0;
		tick(4);
	endtask

	task automatic expect_q(input logic [7:0] e[$]);
		check("fifo count", 8'(q.size()), 8'(e.size()));
		foreach (e[i]) check("fifo byte", q[i], e[i]);
	endtask

	// Watchdog, about four times the expected run
	initial begin
		#25000;
		err_count++;
		report_and_stop();
	end

	// ************************************************
	// Main sequence
	// ************************************************
	initial begin
		{arst_n, reg_wr, reg_rd, crc_done, crc_ok, wor_mode} = 6'h00;
		{reg_addr, reg_wdata} = 14'h0000;
		rx_enable = 1'b1;
		rssi_value = 8'h5A;
		link_quality_value = 7'h33;
		repeat (6) @(posedge core_clk);
		#1;
		arst_n = 1'b1;
		rd(6'h04, 8'hD3, "sync hi");
		rd(6'h05, 8'h91, "sync lo");
		rd(6'h06, 8'hFF, "length limit");
		rd(6'h09, 8'h00, "node address");
		rd(6'h3F, 8'h00, "unmapped");
		wr(6'h03, 8'h0A);
		tick(1);
		check("fifo threshold", 8'(fifo_level_threshold), 8'h0A);
		// Variable length, no preamble, quality gate off
		frame(0, '{8'h03, 8'h11, 8'h22, 8'h33});
		crc(1'b1);
		expect_q('{8'h03, 8'h11, 8'h22, 8'h33, 8'h5A, 8'hB3});
		check("sync count", 8'(n_sync), 8'h01);
		// New sync word, slow sender
		wr(6'h04, 8'h5B);
		wr(6'h05, 8'h2C);
		rd(6'h04, 8'h5B, "sync hi");
		rd(6'h05, 8'h2C, "sync lo");
		{sh, sl} = 16'h5B2C;
		tx.gap = 3;
		frame(1, '{8'h01, 8'h7E});
		tx.gap = 1;
		crc(1'b1);
		expect_q('{8'h01, 8'h7E, 8'h5A, 8'hB3});
		// Autosync and autoflush, status off
		wr(REG_RX_CTRL, 8'h18);
		wor_mode = 1'b1;
		frame(0, '{8'h02, 8'h44, 8'h45});
		crc(1'b0);
		check("flushed count", 8'(q.size()), 8'h00);
		frame(0, '{8'h02, 8'h44, 8'h45});
		crc(1'b1);
		expect_q('{8'h02, 8'h44, 8'h45});
		check("wake resets", 8'(n_wor), 8'h02);
		wor_mode = 1'b0;
		// Fixed length of two
		wr(REG_RX_CTRL, 8'h04);
		wr(REG_PKT_FORMAT, 8'h04);
		wr(REG_PKT_LEN, 8'h02);
		frame(0, '{8'h4C, 8'h4D});
		crc(1'b1);
		expect_q('{8'h4C, 8'h4D, 8'h5A, 8'hB3});
		// Variable length against a limit of two
		wr(REG_PKT_FORMAT, 8'h05);
		frame(0, '{8'h03});
		check("oversize count", 8'(q.size()), 8'h00);
		frame(0, '{8'h02, 8'h61, 8'h62});
		crc(1'b1);
		expect_q('{8'h02, 8'h61, 8'h62, 8'h5A, 8'hB3});
		// Address filter modes, CRC off
		wr(REG_PKT_LEN, 8'hFF);
		wr(REG_PKT_FORMAT, 8'h01);
		wr(REG_NODE_ADDR, 8'h42);
		rd(REG_NODE_ADDR, 8'h42, "node address");
		for (int m = 0; m < 4; m++) begin
			wr(REG_RX_CTRL, 8'h04 | 8'(m));
			foreach (adr[j]) begin
				ok = m == 0 || adr[j] == 8'h42 || (m >= 2 && adr[j] == 8'h00) || (m == 3 && adr[j] == 8'hFF);
				frame(0, '{8'h02, adr[j], 8'h77});
				if (ok) expect_q('{8'h02, adr[j], 8'h77, 8'h5A, 8'hB3});
				else check("filtered count", 8'(q.size()), 8'h00);
			end
		end
		// Quality gate at threshold 28, infinite length
		wr(6'h04, 8'hAA);
		wr(6'h05, 8'hAB);
		{sh, sl} = 16'hAAAB;
		wr(REG_RX_CTRL, 8'hE4);
		wr(REG_PKT_FORMAT, 8'h02);
		for (int k = 0; k < 2; k++) begin
			rx_enable = 1'b0;
			tick(1);
			rx_enable = 1'b1;
			n_sync = 0;
			frame(4 * k, '{8'h01, 8'h66});
			check("gated syncs", 8'(n_sync), 8'(k));
		end
		expect_q('{8'h01, 8'h66});
		report_and_stop();
	end
endmodule // tb

`default_nettype wire
